// File: inc/feat_id_pkg.sv
// constants and types shared by the feature identification register bank
`default_nettype none
package feat_id_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// register offsets inside each feature page
	localparam logic [ADDR_W-1:0] OFF_PRIORITY_FEATURE_ID = 12'h048;
	localparam logic [ADDR_W-1:0] OFF_NARROWING_ID        = 12'h050;
	localparam logic [ADDR_W-1:0] OFF_MONITOR_FEATURE_ID  = 12'h080;

	// narrowing_id fields
	localparam int NRW_MAX_LSB = 0;
	localparam int NRW_MAX_W   = 16;

	// monitor_feature_id fields
	localparam int MON_MBWU_BIT = 17;

	// priority_feature_id fields
	localparam int PRI_HAS_DS_BIT = 16;
	localparam int PRI_DS_WD_LSB  = 20;
	localparam int PRI_DS_WD_W    = 6;
	localparam logic [PRI_DS_WD_W-1:0] PRI_DS_WD_MAX = 6'h10;

	// values after reset
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
	localparam logic              VALID_RST = 1'b0;

	// security space of the page being accessed
	typedef enum logic [1:0]
	{
		SPACE_SECURE    = 2'h0,
		SPACE_NONSECURE = 2'h1,
		SPACE_ROOT      = 2'h2,
		SPACE_REALM     = 2'h3
	} space_t;

	localparam int NUM_SPACES = 4;

	// which register an offset names
	typedef enum logic [3:0]
	{
		REG_NONE = 4'h1,
		REG_PRI  = 4'h2,
		REG_NRW  = 4'h4,
		REG_MON  = 4'h8
	} reg_sel_t;

endpackage
`default_nettype wire

// File: inc/id_sel_if.sv
// selection and identification values passed between the bank and its value table
`timescale 1ns/100ps
`default_nettype none
interface id_sel_if #(parameter int INST_W = 4);
	import feat_id_pkg::*;

	space_t              space;
	logic [INST_W-1:0]   inst;
	logic [DATA_W-1:0]   mon_id;
	logic [DATA_W-1:0]   nrw_id;
	logic [DATA_W-1:0]   pri_id;

	modport requester (output space, output inst, input mon_id, input nrw_id, input pri_id);
	modport provider  (input space, input inst, output mon_id, output nrw_id, output pri_id);
endinterface
`default_nettype wire

// File: design/id_value_mux.sv
// per-space, per-instance identification value table
`timescale 1ns/100ps
`default_nettype none
module id_value_mux
	import feat_id_pkg::*;
#(
	parameter int                                        NUM_INST   = 4,
	parameter int                                        INST_W     = 4,
	parameter bit                                        INST_SEL   = 1'b1,
	parameter logic [NUM_SPACES*NUM_INST-1:0]            MBWU_MAP   = '1,
	parameter logic [NUM_SPACES*NUM_INST*PRI_DS_WD_W-1:0] DS_WD_MAP = '0,
	parameter logic [NUM_SPACES*NRW_MAX_W-1:0]           NRW_MAP    = '0
)
(
	id_sel_if.provider sel
);

	logic [INST_W-1:0]      eff_inst;
	logic [1:0]             sp;
	logic [PRI_DS_WD_W-1:0] raw_wd;
	logic [PRI_DS_WD_W-1:0] ds_wd;

	// instance follows the partition-side selection only when selection exists
	always_comb
	begin
		sp = sel.space;
		eff_inst = '0;
		if (INST_SEL && (int'(sel.inst) < NUM_INST))
			eff_inst = sel.inst;
		raw_wd = DS_WD_MAP[(int'(sp)*NUM_INST+int'(eff_inst))*PRI_DS_WD_W +: PRI_DS_WD_W];
		// a width above the legal top is clamped rather than reported
		ds_wd = (raw_wd > PRI_DS_WD_MAX) ? PRI_DS_WD_MAX : raw_wd;
	end

	// monitoring register: only the bandwidth usage bit is modelled here
	always_comb
	begin
		sel.mon_id = '0;
		sel.mon_id[MON_MBWU_BIT] = MBWU_MAP[int'(sp)*NUM_INST+int'(eff_inst)];
	end

	// narrowing is per space and never looks at the instance
	always_comb
	begin
		sel.nrw_id = '0;
		sel.nrw_id[NRW_MAX_LSB +: NRW_MAX_W] = NRW_MAP[int'(sp)*NRW_MAX_W +: NRW_MAX_W];
	end

	// presence bit derived from the width so the two can never disagree
	always_comb
	begin
		sel.pri_id = '0;
		sel.pri_id[PRI_DS_WD_LSB +: PRI_DS_WD_W] = ds_wd;
		sel.pri_id[PRI_HAS_DS_BIT] = (ds_wd != '0);
	end

endmodule
`default_nettype wire

// File: design/partition_feature_id_regs.sv
// read-only feature identification registers reached through four security pages
`timescale 1ns/100ps
`default_nettype none

module partition_feature_id_regs
	import feat_id_pkg::*;
#(
	parameter int                                         NUM_INST     = 4,
	parameter int                                         INST_W       = 4,
	parameter bit                                         INST_SEL     = 1'b1,
	parameter bit                                         REALM_EXT    = 1'b1,
	parameter bit                                         MON_PRESENT  = 1'b1,
	parameter bit                                         NRW_PRESENT  = 1'b1,
	parameter bit                                         PRI_PRESENT  = 1'b1,
	parameter logic [NUM_SPACES*NUM_INST-1:0]             MBWU_MAP     = '1,
	parameter logic [NUM_SPACES*NUM_INST*PRI_DS_WD_W-1:0] DS_WD_MAP    = '0,
	parameter logic [NUM_SPACES*NRW_MAX_W-1:0]            NRW_MAP      = '0
)
(
	input  wire logic                        mclk,
	input  wire logic                        srst,
	input  wire logic                        req_valid,
	input  wire logic                        req_write,
	input  wire feat_id_pkg::space_t         req_space,
	input  wire logic [feat_id_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [feat_id_pkg::DATA_W-1:0] req_wdata,
	input  wire logic [INST_W-1:0]           partition_select_instance,
	input  wire logic [INST_W-1:0]           monitor_select_instance,
	output logic                             rsp_valid,
	output logic [feat_id_pkg::DATA_W-1:0]   rsp_rdata
);
	import feat_id_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// offset decode, shared by the read path and the checks
	function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
		reg_sel_t r;
		r = REG_NONE;
		if (addr == OFF_MONITOR_FEATURE_ID)
			r = REG_MON;
		else if (addr == OFF_NARROWING_ID)
			r = REG_NRW;
		else if (addr == OFF_PRIORITY_FEATURE_ID)
			r = REG_PRI;
		return r;
	endfunction

	// root and realm pages exist only with the realm extension
	function automatic logic space_open(input space_t sp);
		logic ok;
		ok = 1'b1;
		if ((sp == SPACE_ROOT) || (sp == SPACE_REALM))
			ok = REALM_EXT;
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// value table

	id_sel_if #(.INST_W(INST_W)) sel_bus ();

	// the table is steered by the page and the partition-side instance only;
	// the monitor-side selection is deliberately not wired in
	assign sel_bus.space = req_space;
	assign sel_bus.inst  = partition_select_instance;

	id_value_mux #(
		.NUM_INST  (NUM_INST),
		.INST_W    (INST_W),
		.INST_SEL  (INST_SEL),
		.MBWU_MAP  (MBWU_MAP),
		.DS_WD_MAP (DS_WD_MAP),
		.NRW_MAP   (NRW_MAP)
	) i_id_value_mux (
		.sel (sel_bus.provider)
	);

	////////////////////////////////////////////////////////////////////////////
	// read path

	reg_sel_t               cur_reg;
	logic                   rd_req;
	logic                   nxt_rsp_valid;
	logic [DATA_W-1:0]      nxt_rsp_rdata;
	logic                   rsp_valid_ff;
	logic [DATA_W-1:0]      rsp_rdata_ff;

	assign cur_reg = decode_reg(req_addr);
	assign rd_req  = req_valid && !req_write;

	// every access is answered next cycle; writes answer zero and store nothing
	always_comb
	begin
		nxt_rsp_valid = req_valid;
		nxt_rsp_rdata = RDATA_RST;
		if (rd_req && space_open(req_space))
		begin
			unique case (cur_reg)
				REG_MON: nxt_rsp_rdata = MON_PRESENT ? sel_bus.mon_id : RDATA_RST;
				REG_NRW: nxt_rsp_rdata = NRW_PRESENT ? sel_bus.nrw_id : RDATA_RST;
				REG_PRI: nxt_rsp_rdata = PRI_PRESENT ? sel_bus.pri_id : RDATA_RST;
				REG_NONE: nxt_rsp_rdata = RDATA_RST;
			endcase
		end
	end

	// data leaves through flops; full word width on every answer
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rsp_valid_ff <= VALID_RST;
			rsp_rdata_ff <= RDATA_RST;
		end
		else
		begin
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_rdata_ff <= nxt_rsp_rdata;
		end
	end

	assign rsp_valid = rsp_valid_ff;
	assign rsp_rdata = rsp_rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// a read of register r that also meets cond
	sequence s_rd(reg_sel_t r, untyped cond);
		rd_req && (decode_reg(req_addr) == r) && cond;
	endsequence

	// the same, but only on a page that is open
	sequence s_rd_open(reg_sel_t r, untyped cond);
		rd_req && (decode_reg(req_addr) == r) && space_open(req_space) && cond;
	endsequence

	// same page and partition instance, monitor instance moved between reads
	sequence s_mon_pair;
		s_rd_open(REG_MON, 1'b1) ##1 s_rd_open(REG_MON, $stable(req_space)
			&& $stable(partition_select_instance) && $changed(monitor_select_instance));
	endsequence

	sequence s_nrw_pair;
		s_rd_open(REG_NRW, 1'b1) ##1 s_rd_open(REG_NRW, $stable(req_space)
			&& $changed(partition_select_instance));
	endsequence

	chk_write_ignored: assert property (
		(req_valid && req_write) |=> (rsp_valid && (rsp_rdata == '0)))
		else $error("write was not answered with zero");

	chk_rsp_timing: assert property (
		req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
		else $error("answer not one cycle after request");

	chk_realm_gate: assert property (
		(rd_req && !REALM_EXT && ((req_space == SPACE_ROOT) || (req_space == SPACE_REALM)))
		|=> (rsp_rdata == '0))
		else $error("root or realm page readable without the extension");

	chk_mon_offset: assert property (
		s_rd_open(REG_MON, MON_PRESENT) |=> (rsp_rdata == $past(sel_bus.mon_id)))
		else $error("monitoring register not returned at its offset");

	chk_mon_fields: assert property (
		s_rd(REG_MON, 1'b1) |=> ((rsp_rdata[31:18] == '0) && (rsp_rdata[16:0] == '0)))
		else $error("monitoring register reserved bits set");

	chk_mon_sel_ignored: assert property (
		s_mon_pair |=> (rsp_rdata == $past(rsp_rdata)))
		else $error("monitor instance changed the monitoring register");

	chk_mon_inst_track: assert property (
		s_rd_open(REG_MON, MON_PRESENT && INST_SEL
			&& (int'(partition_select_instance) < NUM_INST))
		|=> (rsp_rdata[MON_MBWU_BIT]
			== MBWU_MAP[int'($past(req_space))*NUM_INST + int'($past(partition_select_instance))]))
		else $error("bandwidth bit does not follow the selected instance");

	chk_nrw_absent: assert property (
		s_rd(REG_NRW, !NRW_PRESENT) |=> (rsp_rdata == '0))
		else $error("narrowing register readable while absent");

	chk_nrw_value: assert property (
		s_rd_open(REG_NRW, NRW_PRESENT) |=> ((rsp_rdata[31:16] == '0)
			&& (rsp_rdata[15:0] == NRW_MAP[int'($past(req_space))*NRW_MAX_W +: NRW_MAX_W])))
		else $error("narrowing register value wrong for this space");

	chk_nrw_global: assert property (
		s_nrw_pair |=> (rsp_rdata == $past(rsp_rdata)))
		else $error("narrowing value moved with the instance");

	chk_nrw_offset: assert property (
		(rd_req && (req_addr == 12'h050) && space_open(req_space) && NRW_PRESENT)
		|=> (rsp_rdata == $past(sel_bus.nrw_id)))
		else $error("narrowing register not at its offset");

	chk_pri_absent: assert property (
		s_rd(REG_PRI, !PRI_PRESENT) |=> (rsp_rdata == '0))
		else $error("priority register readable while absent");

	chk_pri_width: assert property (
		s_rd(REG_PRI, 1'b1) |=> ((rsp_rdata[31:26] == '0) && (rsp_rdata[25:20] <= 6'h10)
			&& (rsp_rdata[16] == (rsp_rdata[25:20] != 6'h00))))
		else $error("downstream width or presence bit inconsistent");

	chk_pri_inst_track: assert property (
		s_rd_open(REG_PRI, PRI_PRESENT) |=> (rsp_rdata == $past(sel_bus.pri_id)))
		else $error("priority register not taken from current selection");

	chk_unmapped_zero: assert property (
		s_rd(REG_NONE, 1'b1) |=> (rsp_rdata == '0))
		else $error("unmapped offset did not read zero");

endmodule
`default_nettype wire

// File: verification/tb_partition_feature_id_regs.sv
// self-checking bench for the feature identification register bank
`timescale 1ns/100ps
`default_nettype none
module tb_partition_feature_id_regs;
	import feat_id_pkg::*;

	// per-space, per-instance maps (narrowing per space only); one width above 16 probes the clamp
	localparam logic [15:0] MBWU = 16'hC3A5;
	localparam logic [63:0] NRW  = 64'h7FFF_0123_00FF_A5A5;
	localparam logic [95:0] DSW  = {6'h14, 6'h00, 6'h10, 6'h01, 6'h03, 6'h08, 6'h00, 6'h0F,
		6'h02, 6'h00, 6'h05, 6'h10, 6'h01, 6'h07, 6'h00, 6'h0C};

	logic              mclk;
	logic              srst;
	logic              req_valid;
	logic              req_write;
	space_t            req_space;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_wdata;
	logic [3:0]        partition_select_instance;
	logic [3:0]        monitor_select_instance;
	logic              rsp_valid;
	logic [DATA_W-1:0] rsp_rdata;
	logic              rsp_valid_b;
	logic              exp_valid;
	logic [DATA_W-1:0] rsp_rdata_b;
	logic [63:0]       notes[$];
	logic [63:0]       note;
	int                fails;
	int                comparisons;
	logic [11:0]       addrs[6] = '{12'h048, 12'h050, 12'h080, 12'h04C, 12'h000, 12'hFFC};

	////////////////////////////////////////////////////////////////////////////////
	// full bank, and a bank without realm pages, instance selection, narrowing or priority
	partition_feature_id_regs #(.MBWU_MAP(MBWU), .DS_WD_MAP(DSW),
		.NRW_MAP(NRW)) i_partition_feature_id_regs (.mclk(mclk), .srst(srst),
		.req_valid(req_valid), .req_write(req_write), .req_space(req_space),
		.req_addr(req_addr), .req_wdata(req_wdata),
		.partition_select_instance(partition_select_instance),
		.monitor_select_instance(monitor_select_instance),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

	partition_feature_id_regs #(.REALM_EXT(1'b0), .INST_SEL(1'b0),
		.NRW_PRESENT(1'b0), .PRI_PRESENT(1'b0), .MBWU_MAP(MBWU), .DS_WD_MAP(DSW),
		.NRW_MAP(NRW)) i_partition_feature_id_regs_min (.mclk(mclk), .srst(srst),
		.req_valid(req_valid), .req_write(req_write), .req_space(req_space),
		.req_addr(req_addr), .req_wdata(req_wdata),
		.partition_select_instance(partition_select_instance),
		.monitor_select_instance(monitor_select_instance),
		.rsp_valid(rsp_valid_b), .rsp_rdata(rsp_rdata_b));

	// 25 ns clock
	always #12.5 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////////////
	// expected word; instances beyond the table, or any instance in the reduced bank
	// (no selection there), fall back to instance 0
	function automatic logic [31:0] expect_word(input bit ext, input bit full, input logic w,
		input space_t sp, input logic [11:0] a, input logic [3:0] ps);
		int          idx;
		logic [5:0]  wd;
		logic [31:0] v;
		idx = int'(sp) * 4 + ((full && (ps < 4'h4)) ? int'(ps) : 0);
		wd = DSW[idx*6 +: 6];
		if (wd > 6'h10)
			wd = 6'h10;
		v = 32'h0000_0000;
		if (w || (!ext && sp >= SPACE_ROOT))
			return v;
		case (a)
			OFF_MONITOR_FEATURE_ID: v[MON_MBWU_BIT] = MBWU[idx];
			OFF_NARROWING_ID: if (full) v[15:0] = NRW[int'(sp)*16 +: 16];
			OFF_PRIORITY_FEATURE_ID: if (full) v = {6'h00, wd, 3'h0, (wd != 6'h00), 16'h0000};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one cycle of stimulus; the expectation is noted when a request is made
	task automatic drive(input logic v, input logic w, input space_t sp, input logic [11:0] a,
		input logic [3:0] ps);
		@(posedge mclk);
		#2;
		req_valid = v;
		req_write = w;
		req_space = sp;
		req_addr = a;
		req_wdata = $urandom;
		partition_select_instance = ps;
		monitor_select_instance = $urandom;
		if (v)
			notes.push_back({expect_word(1, 1, w, sp, a, ps), expect_word(0, 0, w, sp, a, ps)});
	endtask

	task automatic results();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// the bench's own record of which edges took a request
	always @(posedge mclk)
		exp_valid <= req_valid && !srst;

	// response watcher: settled values are taken mid-cycle; the fall at time zero is start-up
	always @(negedge mclk)
	begin
		if ($time > 0)
		begin
			chk({31'h0, rsp_valid}, {31'h0, exp_valid});
			chk({31'h0, rsp_valid_b}, {31'h0, exp_valid});
		end
		if (rsp_valid === 1'b1)
		begin
			if (notes.size() == 0)
				chk(32'h0000_0001, 32'h0000_0000);
			else
			begin
				note = notes.pop_front();
				chk(rsp_rdata, note[63:32]);
				chk(rsp_rdata_b, note[31:0]);
			end
		end
	end

	// the whole run is well under 2000 cycles
	initial
	begin
		#(25 * 5000);
		fails++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		srst = 1'b1;
		fails = 0;
		comparisons = 0;
		void'($urandom(32'h0000E7EB));
		// reset stands over four rising edges
		drive(0, 0, SPACE_SECURE, 12'h000, 4'h0);
		repeat (3) @(posedge mclk);
		#2;
		srst = 1'b0;
		@(negedge mclk);
		chk(rsp_rdata, 32'h0000_0000);
		// every page, offset and instance back to back
		for (int s = 0; s < 4; s++)
			for (int a = 0; a < 6; a++)
				for (int p = 0; p < 5; p++)
					drive(1, 0, space_t'(s), addrs[a], p[3:0]);
		// back to back monitoring reads while only the monitor-side instance moves
		for (int s = 0; s < 4; s++)
			repeat (3)
				drive(1, 0, space_t'(s), OFF_MONITOR_FEATURE_ID, 4'h2);
		// writes answer zero and leave the value in place
		for (int s = 0; s < 4; s++)
			for (int a = 0; a < 3; a++)
			begin
				drive(1, 1, space_t'(s), addrs[a], 4'h1);
				drive(1, 0, space_t'(s), addrs[a], 4'h1);
			end
		// random traffic with gaps and a changing selection
		repeat (400)
			drive($urandom_range(0, 1), $urandom_range(0, 1), space_t'($urandom_range(0, 3)),
				addrs[$urandom_range(0, 5)], $urandom);
		// reset in mid-run with a request held: nothing is answered
		drive(0, 0, SPACE_SECURE, 12'h000, 4'h0);
		@(posedge mclk);
		#2;
		srst = 1'b1;
		req_valid = 1'b1;
		req_addr = OFF_NARROWING_ID;
		repeat (2) @(posedge mclk);
		#2;
		srst = 1'b0;
		req_valid = 1'b0;
		@(negedge mclk);
		chk(rsp_rdata, 32'h0000_0000);
		drive(1, 0, SPACE_REALM, OFF_PRIORITY_FEATURE_ID, 4'h3);
		drive(0, 0, SPACE_SECURE, 12'h000, 4'h0);
		repeat (3) @(posedge mclk);
		chk(notes.size(), 32'h0000_0000);
		results();
	end
endmodule
`default_nettype wire
